// ===== include/hpcr_pkg.sv
// Purpose: shared constants of the host pin configuration register
// Assumes: 16-bit host data port, command-code register access
// Notes: bit positions, command codes and reset value live here; checks and bench also hard-code bit positions and the reset value

package hpcr_pkg;

   // ---------------------------------------------------------------
   // host port command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] HPCR_CMD_READ = 8'h20;
   localparam logic [7:0] HPCR_CMD_WRITE = 8'hA0;

   // ---------------------------------------------------------------
   // field positions of hardware_configuration
   // ---------------------------------------------------------------
   localparam int HPCR_BIT_PULLDOWN = 12;
   localparam int HPCR_BIT_KEEPCLK = 11;
   localparam int HPCR_BIT_ANALOGOC = 10;
   localparam int HPCR_BIT_ACKMODE = 8;
   localparam int HPCR_BIT_ENDLVL = 7;
   localparam int HPCR_BIT_ACKLVL = 6;
   localparam int HPCR_BIT_REQLVL = 5;
   localparam int HPCR_BIT_WIDTH_LO = 3;
   localparam int HPCR_BIT_IRQLVL = 2;
   localparam int HPCR_BIT_IRQEDGE = 1;
   localparam int HPCR_BIT_IRQON = 0;

   // ---------------------------------------------------------------
   // values and masks
   // ---------------------------------------------------------------
   localparam logic [15:0] HPCR_RESET_VALUE = 16'h0028;
   localparam logic [15:0] HPCR_WRITE_MASK = 16'h1DE7;
   localparam logic [15:0] HPCR_FIXED_BITS = 16'h0008;
   localparam logic [1:0] HPCR_WIDTH_16BIT = 2'h1;

   // ---------------------------------------------------------------
   // host port access sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      HPCR_IDLE = 3'b001,
      HPCR_RD_SEL = 3'b010,
      HPCR_WR_SEL = 3'b100
   } hpcr_state_e;

endpackage

// ===== hdl/hpcr_irq_out.sv
// Purpose: interrupt pin driver with polarity, trigger and master enable
// Assumes: sources and enables are synchronous to core_clk
// Notes: output comes straight from a flip-flop

`timescale 1ns/1ns

module hpcr_irq_out #(
   parameter int NSRC = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // interrupt sources and their enables
   input wire logic [NSRC-1:0] srcLevel,
   input wire logic [NSRC-1:0] srcEnable,
   // configuration
   input wire logic masterOn,
   input wire logic edgeSel,
   input wire logic activeHigh,
   // pin
   output logic irqPin
);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   if (NSRC < 1) begin : g_bad_nsrc
      $error("hpcr_irq_out needs at least one source");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [NSRC-1:0] prevGated_r;
   logic [NSRC-1:0] prevGated_nxt;
   logic irqPin_r;
   logic irqPin_nxt;
   logic [NSRC-1:0] gated;
   logic [NSRC-1:0] rising;

   // per-source gating and new-condition detection
   for (genvar i = 0; i < NSRC; i++) begin : g_src
      assign gated[i] = srcLevel[i] & srcEnable[i];
      assign rising[i] = gated[i] & ~prevGated_r[i];
   end

   // pin level: master gate, then level or one-cycle pulse, then polarity
   always_comb begin
      logic asserted;
      asserted = 1'b0;
      prevGated_nxt = masterOn ? gated : '0; // re-enabling the master counts as new
      if (!masterOn) begin
         asserted = 1'b0;
      end else if (edgeSel) begin
         asserted = |rising;
      end else begin
         asserted = |gated;
      end
      irqPin_nxt = activeHigh ? asserted : ~asserted;
   end

   // registers; pin resets inactive for the active-low default
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prevGated_r <= '0;
         irqPin_r <= 1'b1;
      end else begin
         prevGated_r <= prevGated_nxt;
         irqPin_r <= irqPin_nxt;
      end
   end

   assign irqPin = irqPin_r;

endmodule

// ===== hdl/hpcr_top.sv
// Purpose: hardware configuration register and the pin logic it steers
// Assumes: host port strobes are one-cycle pulses synchronous to core_clk
// Notes: a command strobe selects the register; the next data strobe uses it
//
// Notes on behaviour
// - bit 12 one switches internal pull-downs on both downstream ports, zero external
// - bit 11 one keeps clock running in suspend, zero allows stopping
// - bit 10 one selects analog overcurrent sensing, zero digital inputs
// - bit 8 zero: dma acknowledge qualifies strobes; software never writes one
// - bits 7, 5, 2 set end, request, interrupt levels; one high
// - bit 6 acknowledge polarity; only active low supported, software keeps zero
// - bits 4 to 3 read fixed 01 for a 16-bit bus
// - bit 1 zero gives level interrupt held while pending, one edge
// - bit 0 masters interrupt pin together with per-source enables
// - register read with command 20h, written with command a0h

`timescale 1ns/1ns

module hpcr_top
   import hpcr_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int NSRC = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // host command and data port
   input wire logic cmdStrobe,
   input wire logic [7:0] cmdCode,
   input wire logic dataWrStrobe,
   input wire logic [15:0] dataIn,
   input wire logic dataRdStrobe,
   output logic [15:0] dataOut,
   output logic dataOutValid,
   // dma handshake
   input wire logic dmaReqInternal,
   output logic dma_request_pin,
   input wire logic dma_ack_pin,
   input wire logic dmaRdStrobe,
   input wire logic dmaWrStrobe,
   output logic dmaRdGo,
   output logic dmaWrGo,
   input wire logic transfer_end_pin,
   output logic transferEndSeen,
   // downstream port controls
   output logic [NPORT-1:0] pulldownInternalOn,
   input wire logic [NPORT-1:0] ocDigitalIn,
   input wire logic [NPORT-1:0] ocAnalogCmp,
   output logic [NPORT-1:0] overcurrent_sense,
   // suspend clocking
   input wire logic suspendActive,
   output logic clockStopAllowed,
   // interrupt
   input wire logic [NSRC-1:0] irqSources,
   input wire logic [NSRC-1:0] irq_source_enable_reg,
   output logic irqPin
);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   if (NPORT < 1 || NPORT > 2) begin : g_bad_nport
      $error("hpcr_top serves one or two downstream ports");
   end
   // the interrupt driver needs at least one source to gate
   if (NSRC < 1) begin : g_bad_nsrc
      $error("hpcr_top needs at least one interrupt source");
   end

   // ---------------------------------------------------------------
   // register and host port sequencer
   // ---------------------------------------------------------------
   hpcr_state_e state_r;
   hpcr_state_e state_nxt;
   logic [15:0] cfg_r;
   logic [15:0] cfg_nxt;
   logic [15:0] dataOut_r;
   logic [15:0] dataOut_nxt;
   logic dataOutValid_r;
   logic dataOutValid_nxt;

   // command decode, then one data phase on the selected direction;
   // a command strobe wins over a data strobe in the same cycle, so
   // the host must not overlap them or the data word is lost
   always_comb begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      dataOut_nxt = dataOut_r;
      dataOutValid_nxt = 1'b0;
      if (cmdStrobe) begin
         // unknown codes deselect, so stray data strobes do nothing
         if (cmdCode == HPCR_CMD_READ) begin
            state_nxt = HPCR_RD_SEL;
         end else if (cmdCode == HPCR_CMD_WRITE) begin
            state_nxt = HPCR_WR_SEL;
         end else begin
            state_nxt = HPCR_IDLE;
         end
      end else begin
         unique case (state_r)
            HPCR_IDLE: begin
               state_nxt = HPCR_IDLE;
            end
            HPCR_RD_SEL: begin
               if (dataRdStrobe) begin
                  dataOut_nxt = cfg_r;
                  dataOutValid_nxt = 1'b1;
                  state_nxt = HPCR_IDLE;
               end
            end
            HPCR_WR_SEL: begin
               if (dataWrStrobe) begin
                  // reserved bits stay zero, width code stays fixed
                  cfg_nxt = (dataIn & HPCR_WRITE_MASK) | HPCR_FIXED_BITS;
                  state_nxt = HPCR_IDLE;
               end
            end
         endcase
      end
   end

   // register process
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= HPCR_IDLE;
         cfg_r <= HPCR_RESET_VALUE;
         dataOut_r <= '0;
         dataOutValid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         dataOut_r <= dataOut_nxt;
         dataOutValid_r <= dataOutValid_nxt;
      end
   end

   // ---------------------------------------------------------------
   // pin logic steered by the register
   // ---------------------------------------------------------------
   logic dmaReq_r;
   logic dmaReq_nxt;
   logic dmaRdGo_r;
   logic dmaRdGo_nxt;
   logic dmaWrGo_r;
   logic dmaWrGo_nxt;
   logic endSeen_r;
   logic endSeen_nxt;
   logic [NPORT-1:0] pulldown_r;
   logic [NPORT-1:0] pulldown_nxt;
   logic [NPORT-1:0] ocSense_r;
   logic [NPORT-1:0] ocSense_nxt;
   logic clkStop_r;
   logic clkStop_nxt;

   // polarity and select logic; reserved codes of bits 8 and 6 are
   // not honoured, the pins always behave in the supported mode
   always_comb begin
      logic ackActive;
      ackActive = ~dma_ack_pin;
      dmaReq_nxt = cfg_r[HPCR_BIT_REQLVL] ? dmaReqInternal : ~dmaReqInternal;
      dmaRdGo_nxt = dmaRdStrobe & ackActive;
      dmaWrGo_nxt = dmaWrStrobe & ackActive;
      endSeen_nxt = (transfer_end_pin == cfg_r[HPCR_BIT_ENDLVL]);
      pulldown_nxt = {NPORT{cfg_r[HPCR_BIT_PULLDOWN]}};
      ocSense_nxt = cfg_r[HPCR_BIT_ANALOGOC] ? ocAnalogCmp : ocDigitalIn;
      clkStop_nxt = suspendActive & ~cfg_r[HPCR_BIT_KEEPCLK];
   end

   // pin registers; request resets inactive for the active-high default;
   // every pin lags its inputs by one clock, traded for glitch-free outputs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dmaReq_r <= 1'b0;
         dmaRdGo_r <= 1'b0;
         dmaWrGo_r <= 1'b0;
         endSeen_r <= 1'b0;
         pulldown_r <= '0;
         ocSense_r <= '0;
         clkStop_r <= 1'b0;
      end else begin
         dmaReq_r <= dmaReq_nxt;
         dmaRdGo_r <= dmaRdGo_nxt;
         dmaWrGo_r <= dmaWrGo_nxt;
         endSeen_r <= endSeen_nxt;
         pulldown_r <= pulldown_nxt;
         ocSense_r <= ocSense_nxt;
         clkStop_r <= clkStop_nxt;
      end
   end

   // ---------------------------------------------------------------
   // interrupt pin
   // ---------------------------------------------------------------
   hpcr_irq_out #(
      .NSRC(NSRC)
   ) u_irq (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .srcLevel(irqSources),
      .srcEnable(irq_source_enable_reg),
      .masterOn(cfg_r[HPCR_BIT_IRQON]),
      .edgeSel(cfg_r[HPCR_BIT_IRQEDGE]),
      .activeHigh(cfg_r[HPCR_BIT_IRQLVL]),
      .irqPin(irqPin)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // all of these come straight from the registers above; bits 8 and 6
   // read back as written but steer nothing
   assign dataOut = dataOut_r;
   assign dataOutValid = dataOutValid_r;
   assign dma_request_pin = dmaReq_r;
   assign dmaRdGo = dmaRdGo_r;
   assign dmaWrGo = dmaWrGo_r;
   assign transferEndSeen = endSeen_r;
   assign pulldownInternalOn = pulldown_r;
   assign overcurrent_sense = ocSense_r;
   assign clockStopAllowed = clkStop_r;

endmodule

// ===== tb/hpcr_asserts.sv
// Purpose: port checks of hpcr_top
// Assumes: a shadow copy tracks the stored word
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module hpcr_asserts
   import hpcr_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int NSRC = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // host port
   input wire logic cmdStrobe,
   input wire logic [7:0] cmdCode,
   input wire logic dataWrStrobe,
   input wire logic [15:0] dataIn,
   input wire logic dataRdStrobe,
   input wire logic [15:0] dataOut,
   input wire logic dataOutValid,
   // dma handshake
   input wire logic dmaReqInternal,
   input wire logic dma_request_pin,
   input wire logic dma_ack_pin,
   input wire logic dmaRdStrobe,
   input wire logic dmaWrStrobe,
   input wire logic dmaRdGo,
   input wire logic dmaWrGo,
   input wire logic transfer_end_pin,
   input wire logic transferEndSeen,
   // downstream ports and suspend
   input wire logic [NPORT-1:0] pulldownInternalOn,
   input wire logic [NPORT-1:0] ocDigitalIn,
   input wire logic [NPORT-1:0] ocAnalogCmp,
   input wire logic [NPORT-1:0] overcurrent_sense,
   input wire logic suspendActive,
   input wire logic clockStopAllowed,
   // interrupt
   input wire logic [NSRC-1:0] irqSources,
   input wire logic [NSRC-1:0] irq_source_enable_reg,
   input wire logic irqPin
);
   logic [15:0] cfg_r;
   logic [1:0] sel_r;
   logic live_r;
   wire logic [NSRC-1:0] gated = irqSources & irq_source_enable_reg;
   // -------------------------------
   // shadow word and selection
   // -------------------------------
   // live_r masks the first edge, whose outputs still come from reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= HPCR_RESET_VALUE;
         sel_r <= 2'h0;
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
         if (cmdStrobe) begin
            sel_r <= {cmdCode == HPCR_CMD_WRITE, cmdCode == HPCR_CMD_READ};
         end else if (dataWrStrobe && sel_r[1]) begin
            cfg_r <= (dataIn & HPCR_WRITE_MASK) | HPCR_FIXED_BITS;
            sel_r <= 2'h0;
         end else if (dataRdStrobe && sel_r[0]) begin
            sel_r <= 2'h0;
         end
      end
   end
   // -------------------------------
   // properties
   // -------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   a_read_answer: assert property (dataRdStrobe && sel_r[0] && !cmdStrobe
      |=> dataOutValid && dataOut == cfg_r) else $error("bad read answer");
   a_pulldown_follow: assert property (live_r
      |-> pulldownInternalOn == $past({NPORT{cfg_r[12]}})) else $error("bad pull-down select");
   a_clock_stop: assert property (live_r
      |-> clockStopAllowed == $past(suspendActive && !cfg_r[11])) else $error("bad clock stop");
   a_oc_select: assert property (live_r
      |-> overcurrent_sense == $past(cfg_r[10] ? ocAnalogCmp : ocDigitalIn)) else $error("bad sense select");
   a_ack_gate: assert property (live_r
      |-> {dmaRdGo, dmaWrGo} == $past({dmaRdStrobe, dmaWrStrobe} & {2{!dma_ack_pin}})) else $error("bad ack gate");
   a_pin_levels: assert property (live_r
      |-> {dma_request_pin, transferEndSeen} == $past({dmaReqInternal ~^ cfg_r[5], transfer_end_pin ~^ cfg_r[7]}))
      else $error("bad pin level");
   a_irq_masked: assert property (live_r && !$past(cfg_r[0])
      |-> irqPin == !$past(cfg_r[2])) else $error("masked irq active");
   a_irq_level: assert property (live_r && $past(cfg_r[1:0]) == 2'h1
      |-> irqPin == ($past(|gated) ~^ $past(cfg_r[2]))) else $error("bad level irq");
   a_irq_pulse: assert property ($stable(cfg_r) && cfg_r[1:0] == 2'h3 && irqPin == cfg_r[2]
      && (gated & ~$past(gated)) == '0 |=> irqPin != $past(cfg_r[2])) else $error("irq pulse too long");
   // main scenarios reached
   c_read: cover property (dataOutValid);
   c_write: cover property (dataWrStrobe && sel_r[1]);
   c_pulse: cover property (cfg_r[1] && irqPin == cfg_r[2]);
endmodule

bind hpcr_top hpcr_asserts #(.NPORT(NPORT), .NSRC(NSRC)) hpcr_asserts_inst (.*);

// ===== tb/hpcr_host_model.sv
// Purpose: host processor on the command and data port
// Assumes: strobes change 1 ns after a rising edge
// Notes: idle data lines toggle so stale values never look valid
`timescale 1ns/1ns
module hpcr_host_model
   import hpcr_pkg::*;
(
   // clock
   input wire logic core_clk,
   // strobes and data to the device
   output logic cmdStrobe,
   output logic [7:0] cmdCode,
   output logic dataWrStrobe,
   output logic dataRdStrobe,
   output logic [15:0] dataIn,
   // answer
   input wire logic [15:0] dataOut,
   input wire logic dataOutValid
);
   // idle port at time zero
   initial {cmdStrobe, cmdCode, dataWrStrobe, dataRdStrobe, dataIn} = '0;
   // one port cycle
   task automatic cyc(input logic c, input logic [7:0] k, input logic w, r, input logic [15:0] d);
      @(posedge core_clk);
      #1 {cmdStrobe, cmdCode, dataWrStrobe, dataRdStrobe, dataIn} = {c, k, w, r, d};
   endtask
   // write; gap adds idle cycles between command and data
   task automatic wr(input logic [15:0] d, input int gap);
      cyc(1'b1, HPCR_CMD_WRITE, 1'b0, 1'b0, ~dataIn);
      repeat (gap) cyc(1'b0, 8'h00, 1'b0, 1'b0, ~dataIn);
      cyc(1'b0, 8'h00, 1'b1, 1'b0, d & 16'hFEBF);
      cyc(1'b0, 8'h00, 1'b0, 1'b0, ~dataIn);
   endtask
   // read; unknown comes back when no answer marks the word
   task automatic rd(output logic [15:0] q);
      cyc(1'b1, HPCR_CMD_READ, 1'b0, 1'b0, ~dataIn);
      cyc(1'b0, 8'h00, 1'b0, 1'b1, ~dataIn);
      cyc(1'b0, 8'h00, 1'b0, 1'b0, ~dataIn);
      q = (dataOutValid === 1'b1) ? dataOut : 16'hxxxx;
   endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for hpcr_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: one word per access, expectations worked by hand
`timescale 1ns/1ns
module tb_top;
   logic core_clk = 0, arst_n = 0, cmdStrobe, dataWrStrobe, dataRdStrobe, dataOutValid, dmaReqInternal = 0;
   logic dma_request_pin, dma_ack_pin = 0, dmaRdStrobe = 1, dmaWrStrobe = 0, dmaRdGo, dmaWrGo, irqPin;
   logic transfer_end_pin = 0, transferEndSeen, suspendActive = 0, clockStopAllowed;
   logic [7:0] cmdCode;
   logic [15:0] dataIn, dataOut, q, e, irqSources = '0, irq_source_enable_reg = 16'h0001;
   logic [1:0] pulldownInternalOn, ocDigitalIn = 2'h1, ocAnalogCmp = 2'h2, overcurrent_sense;
   int bad_count = 0;
   int checks = 0;
   wire logic [15:0] pinsNow = 16'({pulldownInternalOn, clockStopAllowed, overcurrent_sense,
                                   dma_request_pin, transferEndSeen, dmaRdGo, dmaWrGo});
   hpcr_top hpcr_top_inst (.*);
   hpcr_host_model hpcr_host_model_inst (.*);
   // -------------------------------
   // clock, checks and verdict
   // -------------------------------
   always #50 core_clk = ~core_clk;
   task automatic chk(input logic [15:0] got, exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // drive sources, look one edge later
   task automatic ist(input logic [15:0] s, input logic x);
      @(posedge core_clk);
      #1 irqSources = s;
      @(posedge core_clk);
      #1 chk(16'(irqPin), 16'(x));
   endtask
   // -------------------------------
   // tests
   // -------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      #1 arst_n = 1;
      hpcr_host_model_inst.rd(q);
      chk(q, 16'h0028);
      $display("reset test done");
      for (int b = 1; b >= 0; b--) begin
         hpcr_host_model_inst.wr(b[0] ? 16'hFFFF : 16'h0000, b);
         hpcr_host_model_inst.rd(q);
         chk(q, b[0] ? 16'h1CAF : 16'h0008);
         for (int j = 0; j < 2; j++) begin
            @(posedge core_clk);
            // j=1: request, suspend, acknowledge low and write strobe all active
            #1 {dmaReqInternal, transfer_end_pin, suspendActive, dma_ack_pin, dmaWrStrobe} = {5{j[0]}} ^ 5'h0A;
            ocDigitalIn = j[0] ? 2'h2 : 2'h1;
            ocAnalogCmp = ~ocDigitalIn;
            e = 16'({{2{b[0]}}, j[0] & !b[0], b[0] ? ocAnalogCmp : ocDigitalIn, j[0] ~^ b[0], !j[0] ~^ b[0], {2{j[0]}}});
            @(posedge core_clk);
            #1 chk(pinsNow, e);
         end
      end
      $display("config test done");
      // no selection, unknown code with a strobe in its cycle, then deselected
      hpcr_host_model_inst.cyc(1'b0, 8'h00, 1'b1, 1'b0, 16'hFFFF);
      hpcr_host_model_inst.cyc(1'b1, 8'h21, 1'b1, 1'b0, 16'hFFFF);
      hpcr_host_model_inst.cyc(1'b0, 8'h00, 1'b1, 1'b0, 16'hFFFF);
      hpcr_host_model_inst.rd(q);
      chk(q, 16'h0008);
      $display("refuse test done");
      ist(16'h0001, 1'b1);
      hpcr_host_model_inst.wr(16'h0001, 0);
      ist(16'h0003, 1'b0);
      ist(16'h0002, 1'b1);
      hpcr_host_model_inst.wr(16'h0007, 0);
      ist(16'h0001, 1'b1);
      ist(16'h0001, 1'b0);
      $display("irq test done");
      test_done;
   end
   // tests need about 60 cycles; cut off far beyond that
   initial begin
      #200_000;
      bad_count++;
      test_done;
   end
endmodule
